// >>> rtl/lsi_top.sv
// Purpose: latched status registers, masks, summary and interrupt behind AXI4-Lite
// Assumes: status sources run on clk; host keeps the write-then-read habit
// Notes:   byte address is four times the register index
//
// What this block does
// - each status register has a mask; a bit interrupts only when its mask bit is 1
// - only status registers can drive the interrupt output
// - all writable registers, masks included, clear to zero at reset
// - summary register bits 0-3 flag status registers one-four; bits 4-7 read zero
// - an event or condition sets its status bit and it stays latched until read
// - an event bit clears when read and sets again only on a new event
// - a condition bit stays set after reading while the alarm persists
// - writing ones refreshes those bits of the read copy and clears their latches
// - bits written as zero keep their previous read copy value
// - condition with clearance bit: condition bit on entry, event bit on exit
// - double-interrupt condition bits interrupt when the condition begins and ends
// - information registers latch like status registers but never interrupt
// - live synchroniser information is read-only, unlatched, read without a write
`include "lsi_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module lsi_top #(
  // two kind bits per bit position, status one..four then the information register
  parameter logic [`LSI_NUM_LATCH*`LSI_REG_W*`LSI_KIND_W-1:0] BIT_KIND = 80'h0
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic [`LSI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [`LSI_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`LSI_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [`LSI_DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire lsi_pkg::lsi_src_t       src,
  input  wire logic [`LSI_REG_W-1:0]   e1_sync_live_info,
  output logic                         irq
);

  lsi_pkg::lsi_top_state_t s_q;
  lsi_pkg::lsi_top_state_t s_d;

  logic [`LSI_NUM_LATCH-1:0][`LSI_REG_W-1:0] lat_src;
  logic [`LSI_NUM_LATCH-1:0][`LSI_REG_W-1:0] lat_held;
  logic [`LSI_NUM_LATCH-1:0][`LSI_REG_W-1:0] lat_shown;
  logic [`LSI_NUM_LATCH-1:0]                 lat_wr;
  logic [`LSI_NUM_STAT-1:0]                  summary;
  logic [`LSI_IDX_W-1:0]                     rd_idx;
  logic                                      wr_hit;
  logic                                      rd_hit;
  logic [`LSI_REG_W-1:0]                     rd_byte;

  localparam lsi_pkg::lsi_top_state_t RST_STATE = '{
    wr_st   : lsi_pkg::LSI_WR_IDLE,
    rd_st   : lsi_pkg::LSI_RD_IDLE,
    default : '0
  };

  // ============================================================
  // latched registers: status one..four and the information register
  assign lat_src = {src.info, src.status};

  genvar g;
  generate
    for (g = 0; g < `LSI_NUM_LATCH; g++) begin : g_lat
      lsi_latch #(
        .KIND (BIT_KIND[g*`LSI_REG_W*`LSI_KIND_W +: `LSI_REG_W*`LSI_KIND_W])
      ) u_latch (
        .clk     (clk),
        .sys_rst (sys_rst),
        .src     (lat_src[g]),
        .wr_en   (lat_wr[g]),
        .wr_sel  (s_q.w_byte),
        .held    (lat_held[g]),
        .shown   (lat_shown[g])
      );
    end
  endgenerate

  // ============================================================
  // summary: masked latched bits of the status registers only
  generate
    for (g = 0; g < `LSI_NUM_STAT; g++) begin : g_sum
      // mask bit at one lets the bit through
      assign summary[g] = |(lat_held[g] & s_q.mask[g]);
    end
  endgenerate

  // ============================================================
  // write channel
  always_comb begin
    s_d    = s_q;
    lat_wr = '0;
    wr_hit = 1'b0;

    // address and data are taken independently, in either order
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_idx  = s_axi_awaddr[`LSI_ADDR_W-1:2];
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_have = 1'b1;
      s_d.w_byte = s_axi_wdata[`LSI_REG_W-1:0];
      s_d.w_lane = s_axi_wstrb[0];
    end

    case (s_q.wr_st)
      lsi_pkg::LSI_WR_IDLE: begin
        if (s_q.aw_have && s_q.w_have) begin
          for (int k = 0; k < `LSI_NUM_STAT; k++) begin
            if (s_q.aw_idx == `LSI_IDX_MASK_BASE + `LSI_IDX_W'(k)) begin
              wr_hit = 1'b1;
              if (s_q.w_lane) begin
                s_d.mask[k] = s_q.w_byte;
              end
            end
            if (s_q.aw_idx == `LSI_IDX_STAT_BASE + `LSI_IDX_W'(k)) begin
              wr_hit    = 1'b1;
              lat_wr[k] = s_q.w_lane;
            end
          end
          if (s_q.aw_idx == `LSI_IDX_INFO) begin
            wr_hit                    = 1'b1;
            lat_wr[`LSI_NUM_LATCH-1]  = s_q.w_lane;
          end
          // read-only places take the write and change nothing
          if (s_q.aw_idx == `LSI_IDX_SUMMARY || s_q.aw_idx == `LSI_IDX_E1_LIVE) begin
            wr_hit = 1'b1;
          end
          s_d.bresp   = wr_hit ? `LSI_RESP_OKAY : `LSI_RESP_SLVERR;
          s_d.bvalid  = 1'b1;
          s_d.aw_have = 1'b0;
          s_d.w_have  = 1'b0;
          s_d.wr_st   = lsi_pkg::LSI_WR_RESP;
        end
      end
      lsi_pkg::LSI_WR_RESP: begin
        if (s_axi_bready) begin
          s_d.bvalid = 1'b0;
          s_d.wr_st  = lsi_pkg::LSI_WR_IDLE;
        end
      end
      default: begin
        s_d.bvalid = 1'b0;
        s_d.wr_st  = lsi_pkg::LSI_WR_IDLE;
      end
    endcase

    // one write at a time: no new address or data until the answer is taken
    s_d.awready = !s_d.aw_have && (s_d.wr_st == lsi_pkg::LSI_WR_IDLE);
    s_d.wready  = !s_d.w_have && (s_d.wr_st == lsi_pkg::LSI_WR_IDLE);

    // ============================================================
    // read channel
    rd_idx  = s_axi_araddr[`LSI_ADDR_W-1:2];
    rd_hit  = 1'b0;
    rd_byte = '0;
    for (int k = 0; k < `LSI_NUM_STAT; k++) begin
      if (rd_idx == `LSI_IDX_MASK_BASE + `LSI_IDX_W'(k)) begin
        rd_hit  = 1'b1;
        rd_byte = s_q.mask[k];
      end
      if (rd_idx == `LSI_IDX_STAT_BASE + `LSI_IDX_W'(k)) begin
        rd_hit  = 1'b1;
        // the copy refreshed by the last selection write
        rd_byte = lat_shown[k];
      end
    end
    if (rd_idx == `LSI_IDX_INFO) begin
      rd_hit  = 1'b1;
      rd_byte = lat_shown[`LSI_NUM_LATCH-1];
    end
    if (rd_idx == `LSI_IDX_E1_LIVE) begin
      rd_hit  = 1'b1;
      rd_byte = e1_sync_live_info;
    end
    if (rd_idx == `LSI_IDX_SUMMARY) begin
      rd_hit  = 1'b1;
      // upper bits stay zero
      rd_byte = {{(`LSI_REG_W-`LSI_NUM_STAT){1'b0}}, summary};
    end

    case (s_q.rd_st)
      lsi_pkg::LSI_RD_IDLE: begin
        if (s_q.arready && s_axi_arvalid) begin
          s_d.rdata  = {{(`LSI_DATA_W-`LSI_REG_W){1'b0}}, rd_byte};
          s_d.rresp  = rd_hit ? `LSI_RESP_OKAY : `LSI_RESP_SLVERR;
          s_d.rvalid = 1'b1;
          s_d.rd_st  = lsi_pkg::LSI_RD_RESP;
        end
      end
      lsi_pkg::LSI_RD_RESP: begin
        if (s_axi_rready) begin
          s_d.rvalid = 1'b0;
          s_d.rd_st  = lsi_pkg::LSI_RD_IDLE;
        end
      end
      default: begin
        s_d.rvalid = 1'b0;
        s_d.rd_st  = lsi_pkg::LSI_RD_IDLE;
      end
    endcase
    s_d.arready = (s_d.rd_st == lsi_pkg::LSI_RD_IDLE);

    // ============================================================
    // interrupt: the information register takes no part
    s_d.irq = |summary;
  end

  // ============================================================
  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // masks clear, so nothing interrupts until software enables it
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // outputs straight from the state register
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign irq           = s_q.irq;

endmodule // lsi_top

`default_nettype wire

// >>> rtl/lsi_defs.svh
// Purpose: constants of the latched status interrupt logic
// Assumes: included by bare name from the package and the design modules
// Notes:   register places are indices; the byte address is four times the index
`ifndef LSI_DEFS_SVH
`define LSI_DEFS_SVH

// ============================================================
// bus widths and responses
`define LSI_ADDR_W        8
`define LSI_IDX_W         6
`define LSI_DATA_W        32
`define LSI_RESP_OKAY     2'h0
`define LSI_RESP_SLVERR   2'h2

// ============================================================
// register indices
`define LSI_IDX_INFO      6'h11
`define LSI_IDX_E1_LIVE   6'h12
`define LSI_IDX_SUMMARY   6'h13
`define LSI_IDX_STAT_BASE 6'h14
`define LSI_IDX_MASK_BASE 6'h18

// ============================================================
// counts and bit kinds
`define LSI_NUM_STAT      4
`define LSI_NUM_LATCH     5
`define LSI_REG_W         8
`define LSI_KIND_W        2
`define LSI_KIND_EVT      2'h0
`define LSI_KIND_COND     2'h1
`define LSI_KIND_DBL      2'h2
`define LSI_KIND_CLR      2'h3

`endif

// >>> rtl/lsi_pkg.sv
// Purpose: types shared by the latched status interrupt logic
// Assumes: lsi_defs.svh gives the widths
// Notes:   states are one-hot
`include "lsi_defs.svh"

package lsi_pkg;

  typedef enum logic [1:0] {
    LSI_WR_IDLE = 2'b01,
    LSI_WR_RESP = 2'b10
  } lsi_wr_st_t;

  typedef enum logic [1:0] {
    LSI_RD_IDLE = 2'b01,
    LSI_RD_RESP = 2'b10
  } lsi_rd_st_t;

  // sources from the framer side, same clock
  typedef struct packed {
    logic [`LSI_NUM_STAT-1:0][`LSI_REG_W-1:0] status;
    logic [`LSI_REG_W-1:0]                    info;
  } lsi_src_t;

  typedef struct packed {
    logic [`LSI_REG_W-1:0] prev;
    logic [`LSI_REG_W-1:0] held;
    logic [`LSI_REG_W-1:0] shown;
  } lsi_latch_state_t;

  typedef struct packed {
    lsi_wr_st_t                               wr_st;
    lsi_rd_st_t                               rd_st;
    logic                                     aw_have;
    logic                                     w_have;
    logic [`LSI_IDX_W-1:0]                    aw_idx;
    logic [`LSI_REG_W-1:0]                    w_byte;
    logic                                     w_lane;
    logic                                     awready;
    logic                                     wready;
    logic                                     arready;
    logic                                     bvalid;
    logic [1:0]                               bresp;
    logic                                     rvalid;
    logic [`LSI_DATA_W-1:0]                   rdata;
    logic [1:0]                               rresp;
    logic [`LSI_NUM_STAT-1:0][`LSI_REG_W-1:0] mask;
    logic                                     irq;
  } lsi_top_state_t;

endpackage

// >>> rtl/lsi_latch.sv
// Purpose: one latched status byte with its write-then-read copy
// Assumes: src comes from logic on clk; wr_en is a one-cycle pulse
// Notes:   KIND holds two bits per bit position
`include "lsi_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module lsi_latch #(
  parameter logic [`LSI_REG_W*`LSI_KIND_W-1:0] KIND = 16'h0000
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [`LSI_REG_W-1:0] src,
  input  wire logic                  wr_en,
  input  wire logic [`LSI_REG_W-1:0] wr_sel,
  output logic      [`LSI_REG_W-1:0] held,
  output logic      [`LSI_REG_W-1:0] shown
);

  lsi_pkg::lsi_latch_state_t s_q;
  lsi_pkg::lsi_latch_state_t s_d;
  logic [`LSI_REG_W-1:0]     set_v;
  logic [`LSI_REG_W-1:0]     clr_v;

  // ============================================================
  // set terms per bit
  genvar b;
  generate
    for (b = 0; b < `LSI_REG_W; b++) begin : g_bit
      logic [`LSI_KIND_W-1:0] k;
      logic                   rise;
      logic                   fall;
      assign k    = KIND[b*`LSI_KIND_W +: `LSI_KIND_W];
      assign rise = src[b] & ~s_q.prev[b];
      assign fall = ~src[b] & s_q.prev[b];
      // event: new occurrence only; condition: whole time present
      // double: both edges clearance: leaving the state
      assign set_v[b] = (k == `LSI_KIND_EVT)  ? rise :
                        (k == `LSI_KIND_COND) ? src[b] :
                        (k == `LSI_KIND_DBL)  ? (rise | fall) : fall;
    end
  endgenerate

  // ============================================================
  // latch and readable copy
  always_comb begin
    s_d      = s_q;
    clr_v    = wr_en ? wr_sel : {`LSI_REG_W{1'b0}};
    s_d.prev = src;
    // set wins over the clear so no occurrence is lost
    s_d.held = (s_q.held & ~clr_v) | set_v;
    // selected bits take the latest state, others keep their value
    s_d.shown = (clr_v & (s_q.held | set_v)) | (~clr_v & s_q.shown);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign held  = s_q.held;
  assign shown = s_q.shown;

endmodule // lsi_latch

`default_nettype wire

// >>> bench/lsi_host.sv
// Purpose: host model, register bus master of lsi_top
// Assumes: tasks are called from one bench process
// Notes:   a transfer that times out returns response 2'h3
`timescale 1ns/1ps
`default_nettype none
module lsi_host (
  input  wire logic        clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // ====
  // released payload is inverted so a stale value never looks live
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'h1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] st,
                    output logic [1:0] r);
    r = 2'h3;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h0, v};
    wstrb   <= st;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 64 && r === 2'h3; n++) begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~wdata;
      end
      // bready stands from the request on; the answer is taken when bvalid is seen
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    d = '0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 64 && r === 2'h3; n++) begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  task automatic poll(input logic [7:0] a, input logic [7:0] s, output logic [31:0] d,
                      output logic [1:0] r);
    d = '0;
    wr(a, s, 4'h1, r);
    if (r !== 2'h3) rd(a, d, r);
  endtask
endmodule // lsi_host
`default_nettype wire

// >>> bench/lsi_top_sva.sv
// Purpose: port-level checks of lsi_top
// Assumes: single clock, synchronous reset
// Notes:   bound to every lsi_top
`timescale 1ns/1ps
`default_nettype none
module lsi_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  e1_sync_live_info,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  reset_quiet_a: assert property ($fell(sys_rst) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs busy after reset");
  wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or wide");
  sum_upper_a: assert property (rd_take and s_axi_araddr == 8'h4c |=> s_axi_rdata[7:4] == 4'h0)
    else $error("summary upper bits set");
  live_read_a: assert property (rd_take and s_axi_araddr == 8'h48 |=>
    s_axi_rdata[7:0] == $past(e1_sync_live_info))
    else $error("live info not live");
  irq_fall_a: assert property ($fell(irq) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(sys_rst))
    else $error("interrupt dropped with no host write");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not retired");
endmodule // lsi_chk
bind lsi_top lsi_chk lsi_chk_inst (.*);
`default_nettype wire

// >>> bench/tb_latched_status_interrupt_logic.sv
// Purpose: self-checking bench of lsi_top
// Assumes: status one kinds: bit0 event, bit1 condition, bit2 double, bit3 clearance
// Notes:   byte address is four times the register index
`timescale 1ns/1ps
`default_nettype none
module tb_latched_status_interrupt_logic;
  logic              clk, sys_rst, irq;
  logic [7:0]        awaddr, araddr, e1;
  logic [31:0]       wdata, rdata, d;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, r;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  lsi_pkg::lsi_src_t src;
  int                fail_count, n_tests;
  lsi_top #(.BIT_KIND(80'he4)) lsi_top_inst (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src(src), .e1_sync_live_info(e1), .irq(irq));
  lsi_host lsi_host_inst (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ====
  // helpers
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic guard();
    if (r === 2'h3) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic ci(input logic e);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    lsi_host_inst.wr(a, v, 4'h1, r);
    guard();
    chk({30'h0, r}, 32'h0);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    lsi_host_inst.rd(a, d, r);
    guard();
    chk({30'h0, r}, 32'h0);
    chk(d, {24'h0, e});
  endtask
  task automatic sc(input logic [7:0] a, input logic [7:0] s, input logic [7:0] e);
    lsi_host_inst.poll(a, s, d, r);
    guard();
    chk({30'h0, r}, 32'h0);
    chk(d, {24'h0, e});
  endtask
  task automatic sv(input int i, input int b, input logic v);
    @(posedge clk);
    src.status[i][b] <= v;
  endtask
  // ====
  // scenarios
  task automatic t_reset();
    rc(8'h4c, 8'h00);
    rc(8'h60, 8'h00);
    ci(1'b0);
    $display("t_reset done");
  endtask
  task automatic t_summary();
    for (int i = 0; i < 4; i++) begin
      sv(i, 0, 1'b1);
      sv(i, 0, 1'b0);
    end
    tick(3);
    ci(1'b0);
    rc(8'h4c, 8'h00);
    for (int i = 0; i < 4; i++) w(8'(8'h60 + 4 * i), 8'h01);
    tick(2);
    ci(1'b1);
    rc(8'h4c, 8'h0f);
    w(8'h4c, 8'hff);
    rc(8'h4c, 8'h0f);
    for (int i = 0; i < 4; i++) w(8'(8'h60 + 4 * i), 8'h00);
    tick(2);
    ci(1'b0);
    for (int i = 0; i < 4; i++) w(8'(8'h60 + 4 * i), 8'h01);
    sc(8'h54, 8'h00, 8'h00);
    rc(8'h4c, 8'h0f);
    for (int i = 0; i < 4; i++) sc(8'(8'h50 + 4 * i), 8'h01, 8'h01);
    tick(2);
    ci(1'b0);
    sc(8'h50, 8'h01, 8'h00);
    $display("t_summary done");
  endtask
  task automatic t_kinds();
    w(8'h60, 8'h0e);
    sv(0, 1, 1'b1);
    tick(3);
    ci(1'b1);
    sc(8'h50, 8'h02, 8'h02);
    tick(2);
    ci(1'b1);
    sv(0, 1, 1'b0);
    sc(8'h50, 8'h02, 8'h02);
    sc(8'h50, 8'h02, 8'h00);
    sv(0, 2, 1'b1);
    tick(3);
    ci(1'b1);
    sc(8'h50, 8'h04, 8'h04);
    sv(0, 2, 1'b0);
    tick(3);
    ci(1'b1);
    sc(8'h50, 8'h04, 8'h04);
    sv(0, 3, 1'b1);
    tick(3);
    ci(1'b0);
    sv(0, 3, 1'b0);
    tick(3);
    ci(1'b1);
    sc(8'h50, 8'h08, 8'h0c);
    tick(2);
    ci(1'b0);
    $display("t_kinds done");
  endtask
  task automatic t_info();
    w(8'h60, 8'hff);
    rc(8'h60, 8'hff);
    @(posedge clk);
    src.info[0] <= 1'b1;
    e1 <= 8'h5a;
    @(posedge clk);
    src.info[0] <= 1'b0;
    tick(3);
    ci(1'b0);
    sc(8'h44, 8'h01, 8'h01);
    rc(8'h48, 8'h5a);
    w(8'h48, 8'h00);
    rc(8'h48, 8'h5a);
    // a write with its low lane off must leave the mask untouched
    lsi_host_inst.wr(8'h60, 8'h00, 4'h0, r);
    guard();
    chk({30'h0, r}, 32'h0);
    rc(8'h60, 8'hff);
    lsi_host_inst.wr(8'h00, 8'h01, 4'h1, r);
    chk({30'h0, r}, 32'h2);
    lsi_host_inst.rd(8'h04, d, r);
    chk({30'h0, r}, 32'h2);
    $display("t_info done");
  endtask
  initial begin
    fail_count = 0;
    n_tests = 0;
    src = '0;
    e1 = 8'h00;
    sys_rst = 1'b1;
    tick(20);
    sys_rst <= 1'b0;
    t_reset();
    t_summary();
    t_kinds();
    t_info();
    tally_and_finish();
  end
endmodule // tb_latched_status_interrupt_logic
`default_nettype wire
